//--- btmpc_top.sv
`default_nettype none

module btmpc_top
  import btmpc_pkg::*;
#(
  parameter int IN_W = 4,
  parameter int IO_W = 8,
  parameter int OUT_W = 4,
  parameter int SUM_W = btmpc_pkg::CHK_W
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic board_test_enable_i,
  input wire logic [IN_W-1:0] in_pin_i,
  input wire logic [IO_W-1:0] io_pin_i,
  output logic [IO_W-1:0] io_pin_o,
  output logic [IO_W-1:0] io_oe_o,
  input wire logic [IO_W-1:0] core_io_out_i,
  input wire logic [IO_W-1:0] core_io_oe_i,
  input wire logic [btmpc_pkg::MP_W-1:0] media_port_addr_data_i,
  output logic [btmpc_pkg::MP_W-1:0] media_port_addr_data_o,
  output logic [btmpc_pkg::MP_W-1:0] media_port_addr_data_oe_o,
  input wire logic [btmpc_pkg::MP_W-1:0] core_mp_out_i,
  input wire logic [btmpc_pkg::MP_W-1:0] core_mp_oe_i,
  output logic [btmpc_pkg::MP_W-1:0] core_mp_in_o,
  output logic [OUT_W-1:0] out_pin_o,
  output logic [OUT_W-1:0] out_oe_o,
  input wire logic [OUT_W-1:0] core_out_pin_i,
  input wire logic [OUT_W-1:0] core_out_oe_i,
  input wire btmpc_pkg::btmpc_pix_t pix_i,
  input wire logic pix_active_i,
  input wire logic frame_start_i,
  input wire logic [1:0] chk_colour_i,
  output logic [SUM_W-1:0] chk_sum_o,
  output logic chk_done_o
);

  import btmpc_pkg::*;

  // Number of pins that take part in the NAND chain.
  localparam int TREE_N = MP_W + IO_W + IN_W;

  // ------------------------------------------------------------------
  // Pad test modes.
  // ------------------------------------------------------------------

  // The selector is the low media port nibble in its own bit order.
  wire [SEL_W-1:0] select_w =
    media_port_addr_data_i[SEL_LSB +: SEL_W];

  // The mode is pure logic on pin levels so that a tester can step
  // through modes with the clock stopped; pin levels therefore reach
  // the drivers without synchronisers, which is safe because no
  // register samples them here.
  btmpc_mode_t mode_w;
  assign mode_w = btmpc_decode(board_test_enable_i, select_w);

  // Selector pins are inputs while the enable pin is high.
  wire [MP_W-1:0] mp_hold_w =
    board_test_enable_i ? MP_SEL_MASK : '0;

  // The core never sees the selector as media port data in test.
  assign core_mp_in_o = media_port_addr_data_i & ~mp_hold_w;

  // Chain order: media port first, then bidirectional, then inputs.
  wire [TREE_N-1:0] tree_pins_w =
    {in_pin_i, io_pin_i, media_port_addr_data_i};

  // Output of the last NAND gate.
  logic tree_w;

  // Only output-only pin 0 carries the chain result.
  localparam logic [OUT_W-1:0] TREE_OUT_MASK = OUT_W'(1);

  // Chain across every input and bidirectional path.
  btmpc_nand_tree #(
    .N(TREE_N)
  ) u_tree (
    .pin_i(tree_pins_w),
    .tree_o(tree_w)
  );

  // Bidirectional pins float in the NAND tree so they act as inputs.
  btmpc_pad_mux #(
    .W(IO_W)
  ) u_io_mux (
    .mode_i(mode_w),
    .core_out_i(core_io_out_i),
    .core_oe_i(core_io_oe_i),
    .hold_in_i('0),
    .tree_mask_i('0),
    .tree_i(tree_w),
    .pin_o(io_pin_o),
    .oe_o(io_oe_o)
  );

  // Media port pins, with the selector nibble held as inputs.
  btmpc_pad_mux #(
    .W(MP_W)
  ) u_mp_mux (
    .mode_i(mode_w),
    .core_out_i(core_mp_out_i),
    .core_oe_i(core_mp_oe_i),
    .hold_in_i(mp_hold_w),
    .tree_mask_i('0),
    .tree_i(tree_w),
    .pin_o(media_port_addr_data_o),
    .oe_o(media_port_addr_data_oe_o)
  );

  // Output-only pins; pin 0 loses its normal job in the NAND tree.
  btmpc_pad_mux #(
    .W(OUT_W)
  ) u_out_mux (
    .mode_i(mode_w),
    .core_out_i(core_out_pin_i),
    .core_oe_i(core_out_oe_i),
    .hold_in_i('0),
    .tree_mask_i(TREE_OUT_MASK),
    .tree_i(tree_w),
    .pin_o(out_pin_o),
    .oe_o(out_oe_o)
  );

  // ------------------------------------------------------------------
  // Pixel checksum.
  // ------------------------------------------------------------------

  // Running sum of the current frame.
  logic [SUM_W-1:0] acc_q;
  logic [SUM_W-1:0] acc_d;
  // Published sum of the last complete frame.
  logic [SUM_W-1:0] sum_q;
  logic [SUM_W-1:0] sum_d;
  // Pulse marking a freshly published sum.
  logic done_q;
  logic done_d;
  // Set once a frame start has been seen, so the first partial frame
  // after reset is never published as if it were whole.
  logic seen_q;
  logic seen_d;
  // Colour latched at frame start; a mid-frame change waits a frame.
  logic [1:0] col_q;
  logic [1:0] col_d;

  // A new frame uses the newly requested colour straight away.
  wire [1:0] col_now_w = frame_start_i ? chk_colour_i : col_q;

  // The chosen component at the DAC inputs, one pixel per clock.
  wire [COL_W-1:0] pick_w = btmpc_pick(pix_i, col_now_w);

  // Blanked pixels add nothing; no sync input exists to disturb it.
  wire [SUM_W-1:0] add_w =
    pix_active_i ? SUM_W'(pick_w) : '0;

  // A frame start restarts the sum with the pixel in hand.
  assign acc_d = frame_start_i ? add_w : SUM_W'(acc_q + add_w);
  // The previous frame's total is published only when complete.
  assign sum_d = (frame_start_i && seen_q) ? acc_q : sum_q;
  assign done_d = frame_start_i && seen_q;
  assign seen_d = seen_q | frame_start_i;
  assign col_d = col_now_w;

  // Checksum state; the sum wraps at its own width.
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      acc_q <= '0;
      sum_q <= '0;
      done_q <= DONE_RST;
      seen_q <= SEEN_RST;
      col_q <= COLOUR_RST;
    end else begin
      acc_q <= acc_d;
      sum_q <= sum_d;
      done_q <= done_d;
      seen_q <= seen_d;
      col_q <= col_d;
    end
  end

  // Results leave straight from their registers.
  assign chk_sum_o = sum_q;
  assign chk_done_o = done_q;

  // ------------------------------------------------------------------
  // Checks.
  // ------------------------------------------------------------------

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  // Independent model of the chain: after the last low pin the value
  // is high, and each later high pin inverts it.
  logic tree_ref;
  always_comb begin
    tree_ref = 1'b1;
    for (int i = 0; i < TREE_N; i++) begin
      tree_ref = tree_pins_w[i] ? ~tree_ref : 1'b1;
    end
  end

  // A whole frame ends and the next begins.
  sequence s_frame_end;
    frame_start_i && seen_q;
  endsequence

  // Mid-frame active pixel.
  sequence s_active_pix;
    pix_active_i && !frame_start_i;
  endsequence

  // Mid-frame blanked pixel.
  sequence s_blank_pix;
    !pix_active_i && !frame_start_i;
  endsequence

  AST_NORMAL: assert property (
    !board_test_enable_i |-> io_oe_o == core_io_oe_i &&
      io_pin_o == core_io_out_i && core_mp_in_o == media_port_addr_data_i)
    else $error("normal mode pins differ from core");

  // Output-only and media port drivers also follow the core untouched.
  AST_NORMAL_OUT: assert property (
    !board_test_enable_i |-> out_oe_o == core_out_oe_i &&
      out_pin_o == core_out_pin_i && media_port_addr_data_o == core_mp_out_i
      && media_port_addr_data_oe_o == core_mp_oe_i)
    else $error("normal mode outputs differ from core");

  AST_SEL_HOLD: assert property (
    board_test_enable_i |-> core_mp_in_o[SEL_W-1:0] == '0 &&
      media_port_addr_data_oe_o[SEL_W-1:0] == '0)
    else $error("selector pins not held as inputs");

  AST_NAND_OUT: assert property (
    board_test_enable_i && select_w == SEL_NAND |->
      out_oe_o[0] && out_pin_o[0] == tree_ref && io_oe_o == '0)
    else $error("nand tree result not on output pin");

  AST_NAND_OTHERS: assert property (
    mode_w == MODE_NAND |-> (out_oe_o >> 1) == '0 &&
      media_port_addr_data_oe_o == '0)
    else $error("other pins driven in nand tree");

  AST_FLOAT: assert property (
    board_test_enable_i && select_w == SEL_FLOAT |->
      io_oe_o == '0 && out_oe_o == '0 && media_port_addr_data_oe_o == '0)
    else $error("driver enabled in float mode");

  AST_HIGH: assert property (
    board_test_enable_i && select_w == SEL_HIGH |->
      &io_oe_o && &io_pin_o && &out_oe_o && &out_pin_o)
    else $error("driver not high in outputs high mode");

  AST_LOW: assert property (
    board_test_enable_i && select_w == SEL_LOW |->
      &io_oe_o && io_pin_o == '0 && &out_oe_o && out_pin_o == '0)
    else $error("driver not low in outputs low mode");

  AST_MODE_NOW: assert property (
    $changed(select_w) && board_test_enable_i && select_w == SEL_LOW |->
      out_pin_o == '0)
    else $error("mode change needed a clock edge");

  AST_CHK_ADD: assert property (
    s_active_pix |=> acc_q == SUM_W'($past(acc_q) + $past(pick_w)))
    else $error("active pixel not added");

  AST_CHK_BLANK: assert property (
    s_blank_pix |=> acc_q == $past(acc_q))
    else $error("blanked pixel changed the sum");

  AST_CHK_PUBLISH: assert property (
    s_frame_end |=> chk_done_o && chk_sum_o == $past(acc_q))
    else $error("frame sum not published");

  AST_CHK_HOLD: assert property (
    !(frame_start_i && seen_q) |=> !chk_done_o && $stable(chk_sum_o))
    else $error("published sum moved mid frame");

  // The clear is checked directly, so a stale sum cannot pass vacuously.
  AST_CHK_CLEAR: assert property (
    frame_start_i && !pix_active_i |=>
      (acc_q == '0) and (s_blank_pix |=> acc_q == '0))
    else $error("sum not cleared at frame start");

  // A frame that opens on an active pixel starts from that pixel alone.
  AST_CHK_RESTART: assert property (
    frame_start_i && pix_active_i |=> acc_q == SUM_W'($past(pick_w)))
    else $error("new frame sum did not restart");

endmodule : btmpc_top

`default_nettype wire

//--- btmpc_pkg.sv
`default_nettype none

// Shared constants, types and helpers for board test and pixel checksum.
package btmpc_pkg;

  // Width of the shared media port pin group.
  localparam int MP_W = 8;
  // Width of the test selector carried on the low media port bits.
  localparam int SEL_W = 4;
  // Lowest media port bit that carries the test selector.
  localparam int SEL_LSB = 0;
  // Width of one colour component at the DAC inputs.
  localparam int COL_W = 10;
  // Default checksum accumulator width.
  localparam int CHK_W = 24;

  // Selector codes, bit 3 down to bit 0.
  localparam logic [SEL_W-1:0] SEL_NAND = 4'hA;
  localparam logic [SEL_W-1:0] SEL_FLOAT = 4'hC;
  localparam logic [SEL_W-1:0] SEL_HIGH = 4'hE;
  localparam logic [SEL_W-1:0] SEL_LOW = 4'hF;

  // Media port bits turned into selector inputs while testing.
  localparam logic [MP_W-1:0] MP_SEL_MASK = 8'h0F;

  // Values after reset of the checksum state.
  localparam logic SEEN_RST = 1'b0;
  localparam logic DONE_RST = 1'b0;
  localparam logic [1:0] COLOUR_RST = 2'h0;

  // Pad behaviour chosen by the enable pin and the selector.
  typedef enum logic [2:0] {
    MODE_NORMAL, MODE_NAND, MODE_FLOAT, MODE_HIGH, MODE_LOW
  } btmpc_mode_t;

  // Colour component chosen for accumulation.
  typedef enum logic [1:0] {COL_RED, COL_GREEN, COL_BLUE} btmpc_colour_t;

  // One pixel as it reaches the DAC inputs.
  typedef struct packed {
    logic [COL_W-1:0] red;
    logic [COL_W-1:0] green;
    logic [COL_W-1:0] blue;
  } btmpc_pix_t;

  // Decodes the pad mode from pin levels alone.
  function automatic btmpc_mode_t btmpc_decode(input logic en,
                                               input logic [SEL_W-1:0] sel);
    btmpc_mode_t m;
    m = MODE_NORMAL;
    if (!en) begin
      m = MODE_NORMAL;
    end else if (sel == SEL_NAND) begin
      m = MODE_NAND;
    end else if (sel == SEL_FLOAT) begin
      m = MODE_FLOAT;
    end else if (sel == SEL_HIGH) begin
      m = MODE_HIGH;
    end else if (sel == SEL_LOW) begin
      m = MODE_LOW;
    end
    return m;
  endfunction : btmpc_decode

  // Picks one colour; the unused code 3 reads as blue.
  function automatic logic [COL_W-1:0] btmpc_pick(input btmpc_pix_t p,
                                                  input logic [1:0] c);
    logic [COL_W-1:0] v;
    v = p.blue;
    if (c == COL_RED) begin
      v = p.red;
    end else if (c == COL_GREEN) begin
      v = p.green;
    end
    return v;
  endfunction : btmpc_pick

endpackage : btmpc_pkg

`default_nettype wire

//--- btmpc_nand_tree.sv
`default_nettype none

// Parametric chain of two-input NAND gates across all input paths.
module btmpc_nand_tree #(
  parameter int N = 8
) (
  input wire logic [N-1:0] pin_i,
  output logic tree_o
);

  // Running gate output; the chain head sees a tied-high input.
  logic [N:0] link;

  // Each gate takes the previous output and the next pin.
  always_comb begin
    link = '0;
    link[0] = 1'b1;
    for (int i = 0; i < N; i++) begin
      link[i+1] = ~(link[i] & pin_i[i]);
    end
  end

  // The last gate output leaves for the designated output pin.
  assign tree_o = link[N];

endmodule : btmpc_nand_tree

`default_nettype wire

//--- btmpc_pad_mux.sv
`default_nettype none

// Output driver selection for one group of pins under a pad mode.
module btmpc_pad_mux
  import btmpc_pkg::*;
#(
  parameter int W = 8
) (
  input wire btmpc_pkg::btmpc_mode_t mode_i,
  input wire logic [W-1:0] core_out_i,
  input wire logic [W-1:0] core_oe_i,
  input wire logic [W-1:0] hold_in_i,
  input wire logic [W-1:0] tree_mask_i,
  input wire logic tree_i,
  output logic [W-1:0] pin_o,
  output logic [W-1:0] oe_o
);

  // Forced drive in either level-measurement mode.
  wire force_w = (mode_i == MODE_HIGH) || (mode_i == MODE_LOW);
  // Level forced onto every driver, high or low.
  wire [W-1:0] level_w = (mode_i == MODE_HIGH) ? '1 : '0;
  // Enable before pins that must stay inputs are masked off.
  wire [W-1:0] oe_raw_w =
    (mode_i == MODE_NORMAL) ? core_oe_i :
    (mode_i == MODE_NAND) ? tree_mask_i :
    force_w ? '1 : '0;

  // Selector pins are inputs in test, so they are never driven.
  assign oe_o = oe_raw_w & ~hold_in_i;
  // Data follows the core unless a test mode owns the pin.
  assign pin_o =
    force_w ? level_w :
    (mode_i == MODE_NAND) ? (tree_mask_i & {W{tree_i}}) :
    core_out_i;

endmodule : btmpc_pad_mux

`default_nettype wire

//--- btmpc_tester.sv
`default_nettype none

// Board tester pin model: one line per device pin.
// The tester lets go of a line while the device drives it. Otherwise the
// line takes the tester's own level.
module btmpc_tester #(
  parameter int W = 16
) (
  input wire logic [W-1:0] drv_i,
  input wire logic [W-1:0] dut_d_i,
  input wire logic [W-1:0] dut_oe_i,
  output logic [W-1:0] lvl_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Wire level seen by every receiver, including the selector inputs.
  assign lvl_o = (dut_oe_i & dut_d_i) | (~dut_oe_i & drv_i);

endmodule : btmpc_tester

`default_nettype wire

//--- board_test_mode_and_pixel_checksum_tb_top.sv
`default_nettype none

// Self-checking bench for the pad test modes and the frame checksum.
module board_test_mode_and_pixel_checksum_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import btmpc_pkg::*;

  // A narrow sum, so that wrapping shows within a few frames.
  localparam int SW = 12;
  logic ref_clk = 1'b0;
  logic reset_n;
  logic en;
  logic [3:0] in_pin;
  logic [15:0] drv; // Tester levels: media port high byte, io low byte.
  logic [15:0] lvl;
  logic [7:0] io_o;
  logic [7:0] io_oe;
  logic [7:0] cio;
  logic [7:0] cio_oe;
  logic [7:0] mp_o;
  logic [7:0] mp_oe;
  logic [7:0] cmp;
  logic [7:0] cmp_oe;
  logic [7:0] cmp_in;
  logic [3:0] out_o;
  logic [3:0] out_oe;
  logic [3:0] cout;
  logic [3:0] cout_oe;
  btmpc_pix_t pix;
  logic act;
  logic fs;
  logic [1:0] col;
  logic [SW-1:0] sum;
  logic done;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  // Reference checksum state.
  logic [SW-1:0] acc = '0;
  logic [SW-1:0] pub = '0;
  logic [1:0] lcol = 2'h0;
  logic seen = 1'b0;
  logic edone = 1'b0;

  // Clock of 20 ns period.
  always #10 ref_clk = ~ref_clk;

  btmpc_top #(.SUM_W(SW)) btmpc_top_i (
    .ref_clk_i(ref_clk), .reset_n_i(reset_n), .board_test_enable_i(en),
    .in_pin_i(in_pin), .io_pin_i(lvl[7:0]), .io_pin_o(io_o),
    .io_oe_o(io_oe), .core_io_out_i(cio), .core_io_oe_i(cio_oe),
    .media_port_addr_data_i(lvl[15:8]), .media_port_addr_data_o(mp_o),
    .media_port_addr_data_oe_o(mp_oe), .core_mp_out_i(cmp),
    .core_mp_oe_i(cmp_oe), .core_mp_in_o(cmp_in), .out_pin_o(out_o),
    .out_oe_o(out_oe), .core_out_pin_i(cout), .core_out_oe_i(cout_oe),
    .pix_i(pix), .pix_active_i(act), .frame_start_i(fs),
    .chk_colour_i(col), .chk_sum_o(sum), .chk_done_o(done)
  );

  btmpc_tester #(.W(16)) btmpc_tester_i (
    .drv_i(drv), .dut_d_i({mp_o, io_o}), .dut_oe_i({mp_oe, io_oe}),
    .lvl_o(lvl)
  );

  // Ends the run with the verdict.
  task automatic summarize();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize

  // Compares one seen value with its expectation.
  task automatic check(input logic [31:0] s, input logic [31:0] e,
                       input string m);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, m, s, e);
    end
  endtask : check

  // Independent colour choice; code 3 reads as blue.
  function automatic logic [9:0] pick(input btmpc_pix_t p,
                                      input logic [1:0] c);
    return (c == 2'h0) ? p.red : (c == 2'h1) ? p.green : p.blue;
  endfunction : pick

  // Sets pin levels at an edge; checks follow 1 ns later, with no edge
  // between, so a clocked decode would be caught.
  task automatic pads(input logic e, input logic [7:0] m,
                      input logic [7:0] io, input logic [3:0] ip);
    @(posedge ref_clk);
    en <= e;
    drv <= {m, io};
    in_pin <= ip;
    cio <= 8'($urandom);
    cio_oe <= 8'($urandom);
    cmp <= 8'($urandom);
    cmp_oe <= 8'($urandom);
    cout <= 4'($urandom);
    cout_oe <= 4'($urandom);
    #1;
  endtask : pads

  // Pins follow the core; with t high the selector bits stay inputs.
  task automatic chk_normal(input logic t);
    logic [7:0] k;
    k = t ? 8'hF0 : 8'hFF;
    check({io_o, io_oe}, {cio, cio_oe}, "io pins");
    check({out_o, out_oe}, {cout, cout_oe}, "out pins");
    check(mp_o & k, cmp & k, "mp data");
    check(mp_oe, cmp_oe & k, "mp oe");
    check(cmp_in, lvl[15:8] & k, "mp to core");
  endtask : chk_normal

  // Forced drivers; selector bits are never driven.
  task automatic chk_force(input logic oe, input logic d);
    check({io_oe, out_oe, mp_oe}, {{16{oe}}, 4'h0}, "drivers");
    if (oe) begin
      check({io_o, out_o, mp_o[7:4]}, {16{d}}, "levels");
    end
  endtask : chk_force

  // One pixel clock; outputs are checked against the previous prediction.
  task automatic step(input logic f, input logic [1:0] c);
    btmpc_pix_t p;
    logic a;
    p = btmpc_pix_t'(30'($urandom));
    a = 1'($urandom);
    @(posedge ref_clk);
    pix <= p;
    act <= a;
    fs <= f;
    col <= c;
    #1;
    check(done, edone, "done pulse");
    check(sum, pub, "sum");
    edone = f & seen;
    if (f) begin
      if (seen) begin
        pub = acc;
      end
      seen = 1'b1;
      lcol = c;
      acc = '0;
    end
    // Blank pixels add nothing; the sum wraps at its width.
    if (a) begin
      acc = acc + SW'(pick(p, lcol));
    end
  endtask : step

  // A hang is cut short well beyond the planned run length.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      summarize();
    end
  end

  // Main sequence: every selector code, tree corners, then frames.
  initial begin
    logic [3:0] code;
    int n;
    {en, in_pin, drv, cio, cio_oe, cmp, cmp_oe, cout, cout_oe} = '0;
    pix = '0;
    {act, fs, col, reset_n} = '0;
    void'($urandom(32'h93B8));
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    for (int k = 0; k < 48; k++) begin
      code = (k < 16) ? 4'(k) : 4'($urandom);
      pads(1'b0, {4'($urandom), code}, 8'($urandom), 4'($urandom));
      chk_normal(1'b0);
      pads(1'b1, {4'($urandom), code}, 8'($urandom), 4'($urandom));
      if (code == SEL_FLOAT) begin
        chk_force(1'b0, 1'b0);
      end else if (code == SEL_HIGH) begin
        chk_force(1'b1, 1'b1);
      end else if (code == SEL_LOW) begin
        chk_force(1'b1, 1'b0);
      end else if (code == SEL_NAND) begin
        check(out_oe, 4'h1, "tree pin oe");
        check({io_oe, mp_oe}, 16'h0, "inputs released");
      end else begin
        chk_normal(1'b1);
      end
    end
    // Chain values chosen so the result does not hang on tree length.
    pads(1'b1, 8'h0A, 8'hFF, 4'hF);
    check(out_o[0], 1'b1, "tree out");
    pads(1'b1, 8'h0A, 8'hFF, 4'hB);
    check(out_o[0], 1'b0, "tree out");
    pads(1'b0, 8'h00, 8'h00, 4'h0);
    // Short frames first, back to back, then random lengths.
    for (int f = 0; f < 60; f++) begin
      n = (f < 4) ? 1 : 1 + ($urandom % 30);
      step(1'b1, 2'(f));
      for (int c = 1; c < n; c++) begin
        step(1'b0, 2'($urandom));
      end
    end
    step(1'b1, 2'h0);
    step(1'b0, 2'h0);
    summarize();
  end

endmodule : board_test_mode_and_pixel_checksum_tb_top

`default_nettype wire
